// ===== pwm_ch_cfg.svh
// Register offsets, field positions, edge codes, reset values and counter limits of the width channel
`ifndef PWM_CH_CFG_SVH
`define PWM_CH_CFG_SVH

// Register indices on the plain register port
`define OFS_PERIPH_EN      4'h0
`define OFS_PRESCALE       4'h1
`define OFS_MODE           4'h2
`define OFS_NOISE_FILTER   4'h3
`define OFS_OUT_MODE       4'h4
`define OFS_OUT_LEVEL      4'h5
`define OFS_OUT_ENABLE     4'h6
`define OFS_START_TRIG     4'h7
`define OFS_ENABLE_STATUS  4'h8
`define OFS_CAPTURED       4'h9
`define OFS_COUNTER        4'hA
`define OFS_CHAN_STATUS    4'hB
`define OFS_IRQ_STATUS     4'hC
`define OFS_IRQ_MASK       4'hD

// Field positions
`define BIT_POWER_EN       0
`define BIT_OVERFLOW       0
`define BIT_CLK_SEL        15
`define BIT_MASTER_SPLIT   11
`define BIT_EDGE_HI        7
`define BIT_EDGE_LO        6
`define BIT_IRQ_CAPTURE    0
`define BIT_IRQ_OVERFLOW   1

// Edge select codes
`define EDGE_LOW_WIDTH     2'h2
`define EDGE_HIGH_WIDTH    2'h3

// Reset values and limits
`define RST_WORD           16'h0000
`define RST_BYTE           8'h00
`define COUNT_MAX_16       16'hFFFF
`define COUNT_MAX_8        16'h00FF
`define IRQ_BITS           2
`define CHANNEL_COUNT      8

`endif

// ===== pwm_ch_pkg.sv
// Types shared by the width-measurement channel modules
package pwm_ch_pkg;

    // Gray along stop -> wait -> count
    typedef enum logic [1:0] {
        ST_STOP  = 2'h0,
        ST_WAIT  = 2'h1,
        ST_COUNT = 2'h3
    } chan_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic        tick_a;
        logic        tick_b;
    } presc_state_t;

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       sample;
        logic       level;
        logic       start_edge;
        logic       capture_edge;
    } cond_state_t;

    typedef struct packed {
        logic        power;
        logic [7:0]  prescale;
        logic [15:0] mode;
        logic [7:0]  noise_filter;
        logic [7:0]  out_mode;
        logic [7:0]  out_level;
        logic [7:0]  out_enable;
        logic        enable_status;
        chan_state_t state;
        logic [15:0] counter;
        logic [15:0] captured;
        logic        overflow;
        logic        ovf_pending;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic [15:0] rdata;
        logic        chan_irq;
        logic        irq;
        logic        chan_out;
    } top_state_t;

endpackage

// ===== pwm_edge_if.sv
// Carrier between the channel core and its input conditioner
`timescale 1ns/1ps
interface pwm_edge_if;
    logic       run;
    logic       tick;
    logic       pin;
    logic       filter_en;
    logic [1:0] edge_sel;
    logic       start_edge;
    logic       capture_edge;

    modport core (output run, output tick, output pin, output filter_en, output edge_sel,
                  input start_edge, input capture_edge);
    modport cond (input run, input tick, input pin, input filter_en, input edge_sel,
                  output start_edge, output capture_edge);
endinterface

// ===== pwm_prescaler.sv
// Free-running prescaler that makes the two operating clock enables
`timescale 1ns/1ps
`include "pwm_ch_cfg.svh"
module pwm_prescaler (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [7:0] select,
    output logic            tick_a,
    output logic            tick_b
);
    pwm_ch_pkg::presc_state_t cur;
    pwm_ch_pkg::presc_state_t next_cur;

    // Divide by 2^sel: the tick fires when the low sel bits are all ones
    function automatic logic tick_of(input logic [15:0] cnt, input logic [3:0] sel);
        logic [15:0] mask;
        mask = 16'(( 17'h00001 << sel ) - 17'h00001);
        return (cnt & mask) == mask;
    endfunction

    // Stopped unit clock: counter parked at zero, no ticks
    always_comb
    begin
        next_cur = cur;
        if (!run)
        begin
            next_cur = '0;
        end
        else
        begin
            next_cur.count  = cur.count + 16'h0001;
            next_cur.tick_a = tick_of(cur.count, select[3:0]);
            next_cur.tick_b = tick_of(cur.count, select[7:4]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            cur <= '0;
        else if (ce)
            cur <= next_cur;
    end

    assign tick_a = cur.tick_a;
    assign tick_b = cur.tick_b;
endmodule

// ===== pwm_input_cond.sv
// Input synchroniser, optional noise filter and start/capture edge detector
`timescale 1ns/1ps
`include "pwm_ch_cfg.svh"
module pwm_input_cond (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    pwm_edge_if.cond  eif
);
    pwm_ch_pkg::cond_state_t cur;
    pwm_ch_pkg::cond_state_t next_cur;
    logic                    filtered;
    logic                    high_width;

    // Sampling only on the operating clock costs up to one of its periods of error
    always_comb
    begin
        next_cur              = cur;
        next_cur.start_edge   = 1'b0;
        next_cur.capture_edge = 1'b0;
        high_width = (eif.edge_sel == `EDGE_HIGH_WIDTH);
        // Filter passes a level only once two samples agree
        filtered   = eif.filter_en ? ((cur.sync2 == cur.sample) ? cur.sync2 : cur.level)
                                   : cur.sync2;
        if (!eif.run)
        begin
            next_cur = '0;
        end
        else if (eif.tick)
        begin
            next_cur.sync1  = eif.pin;
            next_cur.sync2  = cur.sync1;
            next_cur.sample = cur.sync2;
            next_cur.level  = filtered;
            // High width starts on rise, low width on fall
            next_cur.start_edge   = (filtered != cur.level) && (filtered == high_width);
            next_cur.capture_edge = (filtered != cur.level) && (filtered != high_width);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            cur <= '0;
        else if (ce)
            cur <= next_cur;
    end

    assign eif.start_edge   = cur.start_edge;
    assign eif.capture_edge = cur.capture_edge;
endmodule

// ===== pulse_width_measure_channel.sv
// Timer channel measuring input pulse width, with unit power gate and register port
`timescale 1ns/1ps
`include "pwm_ch_cfg.svh"
// Function
// - Power enable cleared: unit stopped, its clocks halted, register writes ignored.
// - Setting power enable starts unit clock and accepts writes; channel stays stopped.
// - Power enable at zero: unit register reads and writes are both ignored.
// - Prescaler defines two operating clocks; each channel selects one.
// - Output mode bit zero places the channel in master output mode.
// - In master output mode the output level bit has no effect.
// - Mode bit: master on channel 2, split on 1 and 3, zero on 0.
// - Start trigger bit always reads back zero; it is a pure trigger.
// - Start trigger sets enable status and waits for a start edge.
// - Count from zero after start edge; capture edge stores count and interrupts.
// - Capture sets overflow flag if wrapped; counter halts at captured plus one.
// - Edge select 10 measures low width, 11 measures high width.
// - Start trigger ignored while enable status is already one.
module pulse_width_measure_channel #(
    parameter logic [1:0] CHANNEL_INDEX = 2'h0
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    input  wire logic        CE,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic        CAPTURE_PIN,
    output logic             CHANNEL_IRQ,
    output logic             IRQ,
    output logic             CHANNEL_OUT
);
    pwm_ch_pkg::top_state_t cur;
    pwm_ch_pkg::top_state_t next_cur;
    pwm_edge_if             eif ();
    logic                   tick_a;
    logic                   tick_b;
    logic                   count_tick;
    logic                   wr_unit;
    logic                   rd_unit;
    logic        [15:0]     count_max;
    logic        [15:0]     mode_mask;
    logic        [1:0]      irq_set;
    logic                   chan_bit_mode;
    logic                   chan_bit_level;
    logic                   chan_bit_oe;

    // Write mask on the mode register: the shared bit exists only on channels 1 to 3
    function automatic logic [15:0] mode_write_mask(input logic [1:0] idx);
        logic [15:0] m;
        m = 16'hFFFF;
        if (idx == 2'h0)
            m[`BIT_MASTER_SPLIT] = 1'b0;
        return m;
    endfunction

    // Select this channel's bit from an eight-channel byte register
    function automatic logic chan_bit(input logic [7:0] reg_byte, input logic [1:0] idx);
        return reg_byte[{1'b0, idx}];
    endfunction

    // Two operating clocks from one prescaler; the run input stops it with the unit
    pwm_prescaler u_presc (
        .clk    (CLK_SYS),
        .rst_b  (RST_B),
        .ce     (CE),
        .run    (cur.power),
        .select (cur.prescale),
        .tick_a (tick_a),
        .tick_b (tick_b)
    );

    // Channel picks its operating clock with the clock select bit
    assign count_tick    = cur.mode[`BIT_CLK_SEL] ? tick_b : tick_a;
    assign eif.run       = cur.power;
    assign eif.tick      = count_tick;
    assign eif.pin       = CAPTURE_PIN;
    assign eif.filter_en = chan_bit(cur.noise_filter, CHANNEL_INDEX);
    assign eif.edge_sel  = {cur.mode[`BIT_EDGE_HI], cur.mode[`BIT_EDGE_LO]};

    pwm_input_cond u_cond (
        .clk   (CLK_SYS),
        .rst_b (RST_B),
        .ce    (CE),
        .eif   (eif)
    );

    // Unit registers answer only while the unit is powered
    assign wr_unit   = WR && cur.power;
    assign rd_unit   = RD && cur.power;
    assign mode_mask = mode_write_mask(CHANNEL_INDEX);

    // Split select on channels 1 and 3 narrows the counter to its low byte
    assign count_max = (CHANNEL_INDEX[0] && cur.mode[`BIT_MASTER_SPLIT]) ? `COUNT_MAX_8
                                                                         : `COUNT_MAX_16;

    assign chan_bit_mode  = chan_bit(cur.out_mode, CHANNEL_INDEX);
    assign chan_bit_level = chan_bit(cur.out_level, CHANNEL_INDEX);
    assign chan_bit_oe    = chan_bit(cur.out_enable, CHANNEL_INDEX);

    // Next-state logic: register port, measurement sequencer, interrupt status
    always_comb
    begin
        next_cur          = cur;
        next_cur.chan_irq = 1'b0;
        next_cur.rdata    = `RST_WORD;
        irq_set           = '0;

        // Power enable register stays reachable at all times
        if (WR && ADDR == `OFS_PERIPH_EN)
            next_cur.power = WDATA[`BIT_POWER_EN];

        if (wr_unit)
        begin
            case (ADDR)
                `OFS_PRESCALE:     next_cur.prescale     = WDATA[7:0];
                `OFS_MODE:         next_cur.mode         = WDATA & mode_mask;
                `OFS_NOISE_FILTER: next_cur.noise_filter = WDATA[7:0];
                `OFS_OUT_MODE:     next_cur.out_mode     = WDATA[7:0];
                `OFS_OUT_LEVEL:    next_cur.out_level    = WDATA[7:0];
                `OFS_OUT_ENABLE:   next_cur.out_enable   = WDATA[7:0];
                `OFS_IRQ_MASK:     next_cur.irq_mask     = WDATA[`IRQ_BITS-1:0];
                default:           next_cur.irq_mask     = cur.irq_mask;
            endcase
        end

        // Start trigger: never stored, so it always reads as zero
        if (wr_unit && ADDR == `OFS_START_TRIG && WDATA[{2'h0, CHANNEL_INDEX}])
        begin
            if (!cur.enable_status)
            begin
                next_cur.enable_status = 1'b1;
                next_cur.state         = pwm_ch_pkg::ST_WAIT;
            end
        end

        // Measurement sequencer
        case (cur.state)
            pwm_ch_pkg::ST_STOP:
            begin
                next_cur.state = next_cur.state;
            end
            pwm_ch_pkg::ST_WAIT:
            begin
                if (eif.start_edge)
                begin
                    next_cur.counter     = `RST_WORD;
                    next_cur.ovf_pending = 1'b0;
                    next_cur.state       = pwm_ch_pkg::ST_COUNT;
                end
            end
            pwm_ch_pkg::ST_COUNT:
            begin
                if (eif.capture_edge)
                begin
                    next_cur.captured = cur.counter;
                    next_cur.overflow = cur.ovf_pending;
                    next_cur.counter  = (cur.counter == count_max) ? `RST_WORD
                                                                   : cur.counter + 16'h0001;
                    next_cur.chan_irq = 1'b1;
                    irq_set[`BIT_IRQ_CAPTURE]  = 1'b1;
                    irq_set[`BIT_IRQ_OVERFLOW] = cur.ovf_pending;
                    next_cur.state    = pwm_ch_pkg::ST_WAIT;
                end
                else if (count_tick)
                begin
                    // Wrap remembers one or more full periods as an overflow
                    if (cur.counter == count_max)
                    begin
                        next_cur.counter     = `RST_WORD;
                        next_cur.ovf_pending = 1'b1;
                    end
                    else
                    begin
                        next_cur.counter = cur.counter + 16'h0001;
                    end
                end
            end
            default:
            begin
                next_cur.state = pwm_ch_pkg::ST_STOP;
            end
        endcase

        // Read mux; data appears in the cycle after the strobe
        if (RD && ADDR == `OFS_PERIPH_EN)
            next_cur.rdata = {15'h0000, cur.power};
        else if (rd_unit)
        begin
            case (ADDR)
                `OFS_PRESCALE:      next_cur.rdata = {8'h00, cur.prescale};
                `OFS_MODE:          next_cur.rdata = cur.mode;
                `OFS_NOISE_FILTER:  next_cur.rdata = {8'h00, cur.noise_filter};
                `OFS_OUT_MODE:      next_cur.rdata = {8'h00, cur.out_mode};
                `OFS_OUT_LEVEL:     next_cur.rdata = {8'h00, cur.out_level};
                `OFS_OUT_ENABLE:    next_cur.rdata = {8'h00, cur.out_enable};
                `OFS_START_TRIG:    next_cur.rdata = `RST_WORD;
                `OFS_ENABLE_STATUS: next_cur.rdata = 16'(cur.enable_status) << CHANNEL_INDEX;
                `OFS_CAPTURED:      next_cur.rdata = cur.captured;
                `OFS_COUNTER:       next_cur.rdata = cur.counter;
                `OFS_CHAN_STATUS:   next_cur.rdata = {15'h0000, cur.overflow};
                `OFS_IRQ_STATUS:    next_cur.rdata = {14'h0000, cur.irq_status};
                `OFS_IRQ_MASK:      next_cur.rdata = {14'h0000, cur.irq_mask};
                default:            next_cur.rdata = `RST_WORD;
            endcase
        end

        // Sticky status: a read clears, but an event in the same cycle survives
        if (rd_unit && ADDR == `OFS_IRQ_STATUS)
            next_cur.irq_status = irq_set;
        else
            next_cur.irq_status = cur.irq_status | irq_set;

        // Master mode ignores the level bit; the pin drives only when enabled
        next_cur.chan_out = chan_bit_oe && chan_bit_mode && chan_bit_level;

        // Powered-down unit returns to its reset state and stays there
        if (!next_cur.power)
        begin
            next_cur       = '0;
            next_cur.rdata = (RD && ADDR == `OFS_PERIPH_EN) ? {15'h0000, cur.power} : `RST_WORD;
        end

        next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);
    end

    // Single state register; clock enable freezes everything
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_B)
            cur <= '0;
        else if (CE)
            cur <= next_cur;
    end

    // Outputs come straight from the state register
    assign RDATA       = cur.rdata;
    assign CHANNEL_IRQ = cur.chan_irq;
    assign IRQ         = cur.irq;
    assign CHANNEL_OUT = cur.chan_out;
endmodule

// ===== pwm_chan_monitor.sv
// Port-level assertions for the pulse width channel, bound to its top module
`timescale 1ns/1ps
`include "pwm_ch_cfg.svh"
module pwm_chan_checker #(
    parameter logic [1:0] CHANNEL_INDEX = 2'h0
) (
    input wire logic        CLK_SYS,
    input wire logic        RST_B,
    input wire logic        CE,
    input wire logic [3:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic        CAPTURE_PIN,
    input wire logic        CHANNEL_IRQ,
    input wire logic        IRQ,
    input wire logic        CHANNEL_OUT
);
    logic pw;
    logic mk;
    logic om;
    wire  wr_c = CE && WR;
    wire  rd_c = CE && RD;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    // Mirrors of power, capture mask and output mode; power-off wipes them as it wipes the unit
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_B)
            {pw, mk, om} <= 3'h0;
        else if (wr_c && ADDR == `OFS_PERIPH_EN)
            {pw, mk, om} <= {WDATA[0], mk & WDATA[0], om & WDATA[0]};
        else if (wr_c && pw && ADDR == `OFS_IRQ_MASK)
            mk <= WDATA[`BIT_IRQ_CAPTURE];
        else if (wr_c && pw && ADDR == `OFS_OUT_MODE)
            om <= WDATA[CHANNEL_INDEX];
    end

    // Trigger write followed by a status read
    sequence s_trig;
        wr_c && pw && ADDR == `OFS_START_TRIG && WDATA[CHANNEL_INDEX];
    endsequence
    sequence s_rd_en;
        rd_c && ADDR == `OFS_ENABLE_STATUS;
    endsequence

    property p_off_quiet;
        !pw && $past(!pw) |-> !IRQ && !CHANNEL_IRQ && !CHANNEL_OUT;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("unit active while powered off");
    property p_off_read;
        $past(rd_c && !pw && ADDR != `OFS_PERIPH_EN) |-> RDATA == 16'h0000;
    endproperty
    a_off_read: assert property (p_off_read)
        else $error("read data while powered off");
    property p_trig_zero;
        $past(rd_c && ADDR == `OFS_START_TRIG) |-> RDATA == 16'h0000;
    endproperty
    a_trig_zero: assert property (p_trig_zero)
        else $error("start trigger reads nonzero");
    property p_ch0_fixed;
        $past(rd_c && ADDR == `OFS_MODE) && CHANNEL_INDEX == 2'h0 |-> !RDATA[`BIT_MASTER_SPLIT];
    endproperty
    a_ch0_fixed: assert property (p_ch0_fixed)
        else $error("channel 0 mode bit not fixed");
    property p_trig_status;
        s_trig ##[1:4] s_rd_en |=> RDATA[CHANNEL_INDEX];
    endproperty
    a_trig_status: assert property (p_trig_status)
        else $error("enable status not set by trigger");
    property p_irq_pulse;
        CHANNEL_IRQ |=> !CHANNEL_IRQ;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("channel interrupt longer than one cycle");
    property p_irq_level;
        CHANNEL_IRQ && mk |-> IRQ;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("unmasked capture without interrupt");
    property p_read_clear;
        $past(rd_c && pw && ADDR == `OFS_IRQ_STATUS) && !CHANNEL_IRQ |-> !IRQ;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("interrupt survives status read");
    property p_master_out;
        !om && $past(!om) |-> !CHANNEL_OUT;
    endproperty
    a_master_out: assert property (p_master_out)
        else $error("output driven in master output mode");
endmodule

bind pulse_width_measure_channel pwm_chan_checker #(.CHANNEL_INDEX(CHANNEL_INDEX)) i_chk (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .CAPTURE_PIN(CAPTURE_PIN), .CHANNEL_IRQ(CHANNEL_IRQ),
    .IRQ(IRQ), .CHANNEL_OUT(CHANNEL_OUT)
);

// ===== pwm_pulse_src.sv
// Model of the external pulse source on the capture pin
`timescale 1ns/1ps
module pwm_pulse_src (
    input wire logic clk,
    output logic     pin
);
    logic idle;

    initial
    begin
        idle = 1'b0;
        pin = 1'b0;
    end

    // New resting level; only changed while the channel is stopped, so no false start
    task automatic set_idle(input logic lvl);
        @(posedge clk);
        idle = lvl;
        pin <= lvl;
    endtask

    // One pulse at the active level lasting w clocks, then back to rest
    task automatic pulse(input int w);
        @(posedge clk);
        pin <= !idle;
        repeat (w) @(posedge clk);
        pin <= idle;
    endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the pulse width channel
`timescale 1ns/1ps
`include "pwm_ch_cfg.svh"
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        pin;
    logic        chan_irq;
    logic        irq;
    logic        chan_out;
    logic        ce = 1'b1;
    logic [31:0] rnd = 32'hD85CDED5;
    int          fail_count = 0;
    int          num_checks = 0;
    int          m [16];
    int          widths [$];

    always #4 clk_sys = ~clk_sys;

    pulse_width_measure_channel #(.CHANNEL_INDEX(2'h0)) i_dut (
        .CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .CAPTURE_PIN(pin), .CHANNEL_IRQ(chan_irq),
        .IRQ(irq), .CHANNEL_OUT(chan_out)
    );
    pwm_pulse_src i_src (.clk(clk_sys), .pin(pin));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask

    task automatic report_and_stop;
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One write cycle, then the register model follows it
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        if (a == `OFS_PERIPH_EN && !d[0])
            m = '{default: 0};
        else if (a == `OFS_PERIPH_EN)
            m[0] = 1;
        else if (m[0] != 0 && a inside {4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'hD})
            m[a] = d[7:0];
        else if (m[0] != 0 && a == `OFS_MODE)
            m[a] = d & 16'hF7FF;
        else if (m[0] != 0 && a == `OFS_START_TRIG && d[0])
            m[8] = 1;
    endtask

    // Read data are taken in the cycle after the strobe, where they stand
    task automatic get(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic rd_reg(input logic [3:0] a, input string nm);
        logic [15:0] v;
        get(a, v);
        chk(nm, v, m[a][15:0]);
        if (a == `OFS_IRQ_STATUS)
            m[12] = 0;
    endtask

    task automatic irq_chk;
        chk("irq", {15'h0, irq}, 16'((m[12] & m[13]) != 0));
    endtask

    task automatic out_chk;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("chan_out", {15'h0, chan_out}, 16'(m[4] & m[5] & m[6] & 1));
    endtask

    // One pulse with a trigger while counting; a wrongly taken trigger loses the capture
    task automatic measure(input int w);
        int n;
        int cap;
        logic [15:0] v;
        widths.push_back(w);
        fork
            i_src.pulse(w);
            begin
                repeat (5) @(posedge clk_sys);
                wr_reg(`OFS_START_TRIG, 16'h0001);
            end
        join
        n = 0;
        while (chan_irq !== 1'b1 && n < 200)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        w = widths.pop_front();
        // A lost capture counts once; the run goes on to the closing report
        if (n == 200)
        begin
            fail_count++;
            return;
        end
        m[11] = w > 65536;
        m[12] = m[12] | 1 | (m[11] << 1);
        irq_chk();
        get(`OFS_CAPTURED, v);
        cap = int'(v) + 65536 * m[11] + 1;
        chk("width", {15'h0, cap >= w - 1 && cap <= w + 1}, 16'h0001);
        m[9] = v;
        m[10] = v + 1;
        rd_reg(`OFS_COUNTER, "counter");
        rd_reg(`OFS_CHAN_STATUS, "overflow");
        // Clock enable low: the status read is dropped, read data and status hold
        ce <= 1'b0;
        get(`OFS_IRQ_STATUS, v);
        ce <= 1'b1;
        chk("frozen", v, 16'(m[11]));
        irq_chk();
        rd_reg(`OFS_IRQ_STATUS, "irq_status");
        irq_chk();
    endtask

    initial
    begin
        m = '{default: 0};
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        wr_reg(`OFS_IRQ_MASK, 16'h0003);
        rd_reg(`OFS_IRQ_MASK, "mask_off");
        wr_reg(`OFS_PERIPH_EN, 16'h0001);
        // Random register traffic, then a known clock and filter setting
        for (int i = 1; i < 7; i += 2)
        begin
            rnd = lfsr(rnd);
            wr_reg(i[3:0], rnd[15:0]);
            rd_reg(i[3:0], "rand_reg");
        end
        wr_reg(`OFS_PRESCALE, 16'h0000);
        wr_reg(`OFS_NOISE_FILTER, 16'h0000);
        wr_reg(`OFS_MODE, 16'h88C0);
        rd_reg(`OFS_MODE, "mode");
        wr_reg(`OFS_OUT_LEVEL, 16'h0001);
        wr_reg(`OFS_OUT_ENABLE, 16'h0001);
        out_chk();
        wr_reg(`OFS_OUT_MODE, 16'h0001);
        out_chk();
        // Each edge code: power cycle, set up while stopped, trigger, measure
        // Low width runs on clock b with the filter on; a slow clock a exposes a wrong select
        for (int c = 3; c >= 2; c--)
        begin
            wr_reg(`OFS_PERIPH_EN, 16'h0000);
            i_src.set_idle(c == 2);
            wr_reg(`OFS_PERIPH_EN, 16'h0001);
            rd_reg(`OFS_ENABLE_STATUS, "stopped");
            wr_reg(`OFS_OUT_ENABLE, 16'h0000);
            wr_reg(`OFS_PRESCALE, 16'((3 - c) * 15));
            wr_reg(`OFS_NOISE_FILTER, 16'(3 - c));
            wr_reg(`OFS_MODE, 16'((c << `BIT_EDGE_LO) | ((3 - c) << `BIT_CLK_SEL)));
            wr_reg(`OFS_IRQ_MASK, 16'(c == 3 ? 3 : 0));
            wr_reg(`OFS_START_TRIG, 16'h0001);
            rd_reg(`OFS_START_TRIG, "trigger");
            rd_reg(`OFS_ENABLE_STATUS, "enable");
            wr_reg(`OFS_START_TRIG, 16'h0001);
            for (int k = 0; k < 2; k++)
            begin
                rnd = lfsr(rnd);
                measure(5 + rnd[5:0]);
            end
            if (c == 3)
                measure(65600);
        end
        rd_reg(4'hF, "unmapped");
        wr_reg(`OFS_PERIPH_EN, 16'h0000);
        rd_reg(`OFS_CAPTURED, "cap_off");
        report_and_stop();
    end
endmodule
